// >>> design/idio_regs.svh
// named constants for the isolated digital i/o block
// assumes inclusion by bare name from the synchroniser and the top module
`ifndef IDIO_REGS_SVH
`define IDIO_REGS_SVH

// port index of the dedicated output port
`define IDIO_PORT_OUT 16'h0000
// port index of the dedicated input port
`define IDIO_PORT_IN 16'h0001
// highest legal line index inside a port
`define IDIO_LINE_MAX 16'h0007
// single-line state codes
`define IDIO_STATE_LOW 16'h0000
`define IDIO_STATE_HIGH 16'h0001
// configuration data codes for the direction
`define IDIO_DIR_IN 16'h0000
`define IDIO_DIR_OUT 16'h0001
// reset value of the output holding register
`define IDIO_OUT_RST 8'h00
// fill for the upper half of a read word
`define IDIO_UPPER_ZERO 8'h00
// value returned when a port has nothing to show
`define IDIO_LINES_ZERO 8'h00
// reset value of the synchroniser stages
`define IDIO_SYNC_RST 8'h00
// empty answer word
`define IDIO_WORD_ZERO 16'h0000

`endif

// >>> design/idio_pkg.sv
// types shared by the isolated digital i/o block
// assumes idio_regs.svh is reachable on the include path
package idio_pkg;

  // request kinds from the host side
  typedef enum logic [2:0] {
    IDIO_OP_READ_PORT = 3'h0,
    IDIO_OP_READ_LINE = 3'h1,
    IDIO_OP_WRITE_PORT = 3'h2,
    IDIO_OP_WRITE_LINE = 3'h3,
    IDIO_OP_CONFIG = 3'h4
  } idio_op_t;

  // why a request was refused, or that it was not
  typedef enum logic [2:0] {
    IDIO_CAUSE_NONE = 3'h0,
    IDIO_CAUSE_BAD_PORT = 3'h1,
    IDIO_CAUSE_BAD_LINE = 3'h2,
    IDIO_CAUSE_NOT_OUTPUT = 3'h3,
    IDIO_CAUSE_BAD_VALUE = 3'h4,
    IDIO_CAUSE_BAD_OP = 3'h5
  } idio_cause_t;

  // one host request, taken in a single cycle
  typedef struct packed {
    idio_op_t op;
    logic [15:0] port;
    logic [15:0] line;
    logic [15:0] data;
  } idio_req_t;

  // one answer, one cycle after its request
  typedef struct packed {
    logic [15:0] data;
    logic err;
    logic warn;
    idio_cause_t cause;
  } idio_rsp_t;

endpackage

// >>> design/idio_sync.sv
// three-stage synchroniser with agreement filter for field inputs
// assumes the inputs are asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
`include "idio_regs.svh"

module idio_sync
  import idio_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;

  // per bit: a change counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_comb
      begin
        level_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : level_r[gi];
      end
    end
  endgenerate

  // stage one feeds stage two only, so metastability stays contained
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_r <= WIDTH'(`IDIO_SYNC_RST);
      s2_r <= WIDTH'(`IDIO_SYNC_RST);
      s3_r <= WIDTH'(`IDIO_SYNC_RST);
      level_r <= WIDTH'(`IDIO_SYNC_RST);
    end
    else
    begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;

endmodule
`default_nettype wire

// >>> design/idio_top.sv
// isolated digital i/o ports: one output port, one input port, host request port
// assumes one 50 MHz clock, async high reset, field inputs asynchronous
// assumes at most one request per cycle; the host needs no back-pressure
// assumes field edges are far slower than the clock, so no debounce is kept
// assumes the host treats err as refused and warn as read-back of port 0
// Function
// - Port 0 is the dedicated output port and port 1 the dedicated input port.
// - Only port index 0 and 1 are valid; any other index is refused.
// - Each port has eight lines addressed by line index 0 to 7.
// - A line state is 0 for low and 1 for high, on reads and on writes.
// - Reading port 1 returns the levels the field drives; port 0 in input direction reads zero.
// - Reading the output port in output direction returns its last written value.
// - A port read returns line 0 in bit 0 and each higher line in the next bit.
// - The upper eight bits of every read word are zero.
// - A port write uses only the low eight bits, bit 0 to line 0.
// - A line write changes only the addressed line.
// - A write to a port not in output direction changes nothing and reports an error.
// - Reading the output port in output direction also raises a warning.
// - After reset both ports are in the input direction until configured.
`timescale 1ns/100ps
`default_nettype none
`include "idio_regs.svh"

module idio_top
  import idio_pkg::*;
#(
  parameter int LINES = 8
)
(
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic REQ_VALID_I,
  input wire idio_req_t REQ_I,
  output logic REQ_READY_O,
  output logic RSP_VALID_O,
  output idio_rsp_t RSP_O,
  input wire logic [LINES-1:0] FIELD_IN_I,
  output logic [LINES-1:0] FIELD_OUT_O,
  output logic FIELD_OUT_EN_O
);

  // output port state
  logic [LINES-1:0] out_r;
  logic [LINES-1:0] out_nxt;
  logic dir_out_r;
  logic dir_out_nxt;

  // answer state
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  idio_rsp_t rsp_r;
  idio_rsp_t rsp_nxt;

  // filtered field inputs
  logic [LINES-1:0] in_lvl;

  // request decode
  logic port_is_out;
  logic port_is_in;
  logic port_ok;
  logic line_ok;
  logic state_ok;
  logic dir_ok;
  logic [2:0] line_sel;
  logic [LINES-1:0] port_lines;
  logic [LINES-1:0] line_write_val;
  logic is_write;
  // writes land only on port 0 while it drives
  logic out_writable;
  logic wr_refused;

  // field inputs come from another domain, so they pass the filter
  // a stable pin shows in reads four edges later; one-cycle glitches never do
  idio_sync #(
    .WIDTH(LINES)
  ) u_sync (
    .clk_i(REF_CLK_I),
    .rst_i(SYS_RST_I),
    .async_i(FIELD_IN_I),
    .level_o(in_lvl)
  );

  // every request is answered in one cycle, so the port never stalls
  // a held REQ_VALID_I counts as one request per cycle
  assign REQ_READY_O = 1'b1;

  // index checks against the two legal ports and eight lines
  // indexes stay 16 bits wide so out-of-range values can be refused
  always_comb
  begin
    port_is_out = (REQ_I.port == `IDIO_PORT_OUT);
    port_is_in = (REQ_I.port == `IDIO_PORT_IN);
    port_ok = port_is_out || port_is_in;
    line_ok = (REQ_I.line <= `IDIO_LINE_MAX);
    state_ok = (REQ_I.data == `IDIO_STATE_LOW) || (REQ_I.data == `IDIO_STATE_HIGH);
    dir_ok = (REQ_I.data == `IDIO_DIR_IN) || (REQ_I.data == `IDIO_DIR_OUT);
    line_sel = REQ_I.line[2:0];
    is_write = (REQ_I.op == IDIO_OP_WRITE_PORT) || (REQ_I.op == IDIO_OP_WRITE_LINE);
    out_writable = port_is_out && dir_out_r;
    wr_refused = is_write && !out_writable;
  end

  // what the addressed port shows right now
  // registered output, so a read right after a write already sees it
  always_comb
  begin
    if (port_is_out)
    begin
      // port 0 has no field inputs; in input direction it shows nothing
      port_lines = dir_out_r ? out_r : `IDIO_LINES_ZERO;
    end
    else
    begin
      port_lines = in_lvl;
    end
  end

  // per line: only the addressed bit takes the new state
  // line_sel wraps above 7, but line_ok refuses those before use
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++)
    begin : g_line
      always_comb
      begin
        line_write_val[gi] = (line_sel == 3'(gi)) ? REQ_I.data[0] : out_r[gi];
      end
    end
  endgenerate

  // next state of the output port and its direction
  // reads never move state; only accepted writes and configs do
  always_comb
  begin
    out_nxt = out_r;
    dir_out_nxt = dir_out_r;
    if (REQ_VALID_I)
    begin
      unique case (REQ_I.op)
        IDIO_OP_WRITE_PORT:
        begin
          // refused writes fall through and keep every line
          if (out_writable)
          begin
            out_nxt = REQ_I.data[LINES-1:0];
          end
        end
        IDIO_OP_WRITE_LINE:
        begin
          if (out_writable && line_ok && state_ok)
          begin
            out_nxt = line_write_val;
          end
        end
        IDIO_OP_CONFIG:
        begin
          // only port 0 may turn to output; port 1 stays input
          // the value is kept, so turning back to output restores the pattern
          if (port_is_out && dir_ok)
          begin
            dir_out_nxt = (REQ_I.data == `IDIO_DIR_OUT);
          end
        end
        default:
        begin
          out_nxt = out_r;
        end
      endcase
    end
  end

  // next answer: data, error and warning, one cycle after the request
  // refusals are checked in the order port, line, direction, value; config checks value before direction
  always_comb
  begin
    rsp_valid_nxt = REQ_VALID_I;
    rsp_nxt.data = `IDIO_WORD_ZERO;
    rsp_nxt.err = 1'b0;
    rsp_nxt.warn = 1'b0;
    rsp_nxt.cause = IDIO_CAUSE_NONE;
    if (REQ_VALID_I)
    begin
      if (!port_ok)
      begin
        rsp_nxt.err = 1'b1;
        rsp_nxt.cause = IDIO_CAUSE_BAD_PORT;
      end
      else
      begin
        unique case (REQ_I.op)
          IDIO_OP_READ_PORT:
          begin
            // warning only when port 0 drives; field reads never warn
            rsp_nxt.data = {`IDIO_UPPER_ZERO, port_lines};
            rsp_nxt.warn = out_writable;
          end
          IDIO_OP_READ_LINE:
          begin
            if (!line_ok)
            begin
              rsp_nxt.err = 1'b1;
              rsp_nxt.cause = IDIO_CAUSE_BAD_LINE;
            end
            else
            begin
              // state sits in bit 0 as 0 or 1
              rsp_nxt.data = {15'h0000, port_lines[line_sel]};
              rsp_nxt.warn = out_writable;
            end
          end
          IDIO_OP_WRITE_PORT:
          begin
            if (wr_refused)
            begin
              rsp_nxt.err = 1'b1;
              rsp_nxt.cause = IDIO_CAUSE_NOT_OUTPUT;
            end
          end
          IDIO_OP_WRITE_LINE:
          begin
            if (!line_ok)
            begin
              rsp_nxt.err = 1'b1;
              rsp_nxt.cause = IDIO_CAUSE_BAD_LINE;
            end
            else if (wr_refused)
            begin
              rsp_nxt.err = 1'b1;
              rsp_nxt.cause = IDIO_CAUSE_NOT_OUTPUT;
            end
            else if (!state_ok)
            begin
              rsp_nxt.err = 1'b1;
              rsp_nxt.cause = IDIO_CAUSE_BAD_VALUE;
            end
          end
          IDIO_OP_CONFIG:
          begin
            if (!dir_ok)
            begin
              rsp_nxt.err = 1'b1;
              rsp_nxt.cause = IDIO_CAUSE_BAD_VALUE;
            end
            else if (port_is_in && (REQ_I.data == `IDIO_DIR_OUT))
            begin
              // the input port has no drivers, so output is refused
              rsp_nxt.err = 1'b1;
              rsp_nxt.cause = IDIO_CAUSE_NOT_OUTPUT;
            end
          end
          default:
          begin
            rsp_nxt.err = 1'b1;
            rsp_nxt.cause = IDIO_CAUSE_BAD_OP;
          end
        endcase
      end
    end
  end

  // output port registers; reset leaves both ports as inputs
  // async reset quiets the pins even while the clock is stopped
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      out_r <= LINES'(`IDIO_OUT_RST);
      dir_out_r <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
      dir_out_r <= dir_out_nxt;
    end
  end

  // answer registers
  // a zero answer between requests keeps idle cycles clean
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end
    else
    begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  // pins hold the register value between writes
  // the enable marks drive; the value itself survives direction changes
  assign FIELD_OUT_O = out_r;
  assign FIELD_OUT_EN_O = dir_out_r;
  assign RSP_VALID_O = rsp_valid_r;
  assign RSP_O = rsp_r;

endmodule
`default_nettype wire

// >>> tb/idio_top_assertions.sv
// concurrent checks on the isolated digital i/o top ports
// assumes idio_pkg is compiled first; bound into every idio_top
`timescale 1ns/100ps
`default_nettype none
module idio_chk
  import idio_pkg::*;
#(
  parameter int LINES = 8
)
(
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic REQ_VALID_I,
  input wire idio_req_t REQ_I,
  input wire logic REQ_READY_O,
  input wire logic RSP_VALID_O,
  input wire idio_rsp_t RSP_O,
  input wire logic [LINES-1:0] FIELD_IN_I,
  input wire logic [LINES-1:0] FIELD_OUT_O,
  input wire logic FIELD_OUT_EN_O
);
  logic wr;
  // request aimed at the driving output port
  assign wr = REQ_VALID_I && FIELD_OUT_EN_O && REQ_I.port == 16'h0000;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  AST_ANSWER: assert property (REQ_VALID_I |=> RSP_VALID_O)
    else $error("request without answer");
  AST_QUIET: assert property (!REQ_VALID_I |=> !RSP_VALID_O && $stable(FIELD_OUT_O))
    else $error("output moved without request");
  AST_DIR_HOLD: assert property (!REQ_VALID_I |=> $stable(FIELD_OUT_EN_O))
    else $error("direction moved without request");
  AST_UPPER: assert property (RSP_VALID_O |-> RSP_O.data[15:8] == 8'h00)
    else $error("upper read byte not zero");
  AST_PORT: assert property (REQ_VALID_I && REQ_I.port > 16'h0001
    |=> RSP_O.err && $stable(FIELD_OUT_O))
    else $error("bad port accepted");
  AST_NOT_OUT: assert property (REQ_VALID_I && !wr && (REQ_I.op == IDIO_OP_WRITE_PORT
    || REQ_I.op == IDIO_OP_WRITE_LINE) |=> RSP_O.err && $stable(FIELD_OUT_O))
    else $error("write to non-output port accepted");
  AST_WPORT: assert property (wr && REQ_I.op == IDIO_OP_WRITE_PORT
    |=> FIELD_OUT_O == $past(REQ_I.data[7:0]))
    else $error("port write value wrong");
  AST_WLINE: assert property (wr && REQ_I.op == IDIO_OP_WRITE_LINE
    && REQ_I.line < 16'h0008 && REQ_I.data < 16'h0002
    |=> FIELD_OUT_O[$past(REQ_I.line[2:0])] == $past(REQ_I.data[0]))
    else $error("line write wrong");
  AST_RBACK: assert property (wr && REQ_I.op == IDIO_OP_READ_PORT
    |=> RSP_O.warn && RSP_O.data == {8'h00, FIELD_OUT_O})
    else $error("read-back wrong");
  AST_READY: assert property (REQ_READY_O)
    else $error("request port not ready");
  AST_CFG: assert property (REQ_VALID_I && REQ_I.op == IDIO_OP_CONFIG
    && REQ_I.port == 16'h0000 && REQ_I.data < 16'h0002
    |=> FIELD_OUT_EN_O == $past(REQ_I.data[0]))
    else $error("direction config not applied");
  C_WPORT: cover property (wr && REQ_I.op == IDIO_OP_WRITE_PORT);
  C_REFUSE: cover property (RSP_VALID_O && RSP_O.err);
  C_WARN: cover property (RSP_VALID_O && RSP_O.warn);
endmodule
bind idio_top idio_chk #(.LINES(LINES)) u_chk (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
  .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .REQ_READY_O(REQ_READY_O),
  .RSP_VALID_O(RSP_VALID_O), .RSP_O(RSP_O), .FIELD_IN_I(FIELD_IN_I),
  .FIELD_OUT_O(FIELD_OUT_O), .FIELD_OUT_EN_O(FIELD_OUT_EN_O));
`default_nettype wire

// >>> tb/idio_field.sv
// field-side model: equipment driving the isolated input lines
// assumes the pattern comes from the bench; lines always driven
`timescale 1ns/100ps
`default_nettype none
module idio_field
(
  input wire logic clk_i,
  input wire logic [7:0] pat_i,
  output logic [7:0] lines_o
);
  initial lines_o = 8'h00;
  // skewed from the edge so the block sees an unrelated phase
  always @(posedge clk_i)
    lines_o <= #7 pat_i;
endmodule
`default_nettype wire

// >>> tb/idio_top_tb.sv
// self-checking bench for the isolated digital i/o ports
// assumes idio_pkg, the design and the field model are compiled
`timescale 1ns/100ps
`default_nettype none
module idio_top_tb;
  import idio_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic valid = 1'b0;
  idio_req_t rq = '0;
  logic [7:0] pat = 8'h00;
  logic [7:0] fin;
  logic [7:0] fout;
  logic rv;
  logic en;
  idio_rsp_t rsp;
  idio_rsp_t r;
  int bad_count = 0;
  int comparisons = 0;
  // 50 MHz
  always #10 clk = ~clk;
  idio_top DUT (.REF_CLK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(valid), .REQ_I(rq),
    .REQ_READY_O(), .RSP_VALID_O(rv), .RSP_O(rsp), .FIELD_IN_I(fin),
    .FIELD_OUT_O(fout), .FIELD_OUT_EN_O(en));
  idio_field FLD (.clk_i(clk), .pat_i(pat), .lines_o(fin));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one request; the answer must come one cycle later
  task automatic req(input logic [2:0] op, input logic [15:0] p, l, d);
    int n;
    n = 0;
    rq = {op, p, l, d};
    valid = 1'b1;
    @(posedge clk);
    #1;
    valid = 1'b0;
    while (rv !== 1'b1 && n < 3)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'h0000);
    if (n == 3)
      test_done();
    else
    begin
      r = rsp;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_reset;
    chk({7'h00, en, fout}, 16'h0000);
    req(3'h2, 16'h0000, 16'h0000, 16'h00FF);
    chk({12'h000, r.err, r.cause}, 16'h000B);
    chk({8'h00, fout}, 16'h0000);
    req(3'h0, 16'h0000, 16'h0000, 16'h0000);
    chk(r.data, 16'h0000);
    chk({15'h0000, r.warn}, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_out;
    req(3'h4, 16'h0000, 16'h0000, 16'h0001);
    chk({15'h0000, en}, 16'h0001);
    req(3'h2, 16'h0000, 16'h0000, 16'hFFA5);
    chk({8'h00, fout}, 16'h00A5);
    req(3'h0, 16'h0000, 16'h0000, 16'h0000);
    chk(r.data, 16'h00A5);
    chk({15'h0000, r.warn}, 16'h0001);
    req(3'h3, 16'h0000, 16'h0001, 16'h0001);
    chk({8'h00, fout}, 16'h00A7);
    req(3'h3, 16'h0000, 16'h0000, 16'h0000);
    chk({8'h00, fout}, 16'h00A6);
    req(3'h1, 16'h0000, 16'h0002, 16'h0000);
    chk(r.data, 16'h0001);
    req(3'h2, 16'h0001, 16'h0000, 16'h0000);
    chk({12'h000, r.err, r.cause}, 16'h000B);
    req(3'h0, 16'h0002, 16'h0000, 16'h0000);
    chk({12'h000, r.err, r.cause}, 16'h0009);
    req(3'h3, 16'h0000, 16'h0008, 16'h0001);
    chk({12'h000, r.err, r.cause}, 16'h000A);
    req(3'h1, 16'h0001, 16'h0008, 16'h0000);
    chk({12'h000, r.err, r.cause}, 16'h000A);
    req(3'h3, 16'h0000, 16'h0003, 16'h0002);
    chk({12'h000, r.err, r.cause}, 16'h000C);
    chk({8'h00, fout}, 16'h00A6);
    req(3'h4, 16'h0001, 16'h0000, 16'h0001);
    chk({12'h000, r.err, r.cause}, 16'h000B);
    req(3'h4, 16'h0000, 16'h0000, 16'h0002);
    chk({12'h000, r.err, r.cause}, 16'h000C);
    chk({15'h0000, en}, 16'h0001);
    req(3'h5, 16'h0000, 16'h0000, 16'h0000);
    chk({12'h000, r.err, r.cause}, 16'h000D);
    req(3'h4, 16'h0000, 16'h0000, 16'h0000);
    req(3'h2, 16'h0000, 16'h0000, 16'h0000);
    chk({12'h000, r.err, r.cause}, 16'h000B);
    chk({7'h00, en, fout}, 16'h00A6);
    $display("output test done");
  endtask
  task automatic t_in;
    pat = 8'h2C;
    repeat (8) @(posedge clk);
    #1;
    req(3'h0, 16'h0001, 16'h0000, 16'h0000);
    chk(r.data, 16'h002C);
    chk({15'h0000, r.warn}, 16'h0000);
    req(3'h1, 16'h0001, 16'h0005, 16'h0000);
    chk(r.data, 16'h0001);
    req(3'h1, 16'h0001, 16'h0006, 16'h0000);
    chk(r.data, 16'h0000);
    $display("input test done");
  endtask
  task automatic t_rst2;
    req(3'h4, 16'h0000, 16'h0000, 16'h0001);
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    chk({7'h00, en, fout}, 16'h0000);
    req(3'h2, 16'h0000, 16'h0000, 16'h0055);
    chk({12'h000, r.err, r.cause}, 16'h000B);
    chk({8'h00, fout}, 16'h0000);
    $display("second reset test done");
  endtask
  // reset for 8 cycles, then the scenarios
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_out();
    t_in();
    t_rst2();
    test_done();
  end
endmodule
`default_nettype wire
